// ---- rtl/bit_mask_decoder.v ----
`timescale 1ns/1ps
module bit_mask_decoder (
	sel,
	mask_n
);
	input  wire [2:0] sel;
	output wire [7:0] mask_n;

	// always enabled: exactly one output low at any time
	assign mask_n = ~(8'h01 << sel);
endmodule

// ---- rtl/data_ram.v ----
`timescale 1ns/1ps
module data_ram (
	clk,
	ce,
	we,
	addr,
	wdata,
	rdata
);
	input  wire       clk;
	input  wire       ce;
	input  wire       we;
	input  wire [7:0] addr;
	input  wire [7:0] wdata;
	output wire [7:0] rdata;

	reg [7:0] mem [0:255];

	always @(posedge clk) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
	end

	// asynchronous read so the bus sees the word in the same cycle
	assign rdata = mem[addr];
endmodule

// ---- rtl/printer_bus_defs.vh ----
`ifndef PRINTER_BUS_DEFS_VH
`define PRINTER_BUS_DEFS_VH

// ---------------------------------------------------------------
// register map, byte addresses
// ---------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_RAM_ADDR    8'h04
`define OFS_ACCS        8'h08
`define OFS_FLAGS       8'h0C
`define CTRL_CLEAR_BIT  0
`define CTRL_GATE_BIT   1
`define CTRL_RESET      2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ---------------------------------------------------------------
// instruction word fields
// ---------------------------------------------------------------
`define INST_ALU        0
`define INST_RMASK_LO   10
`define INST_RMASK_EN   13
`define INST_RDEN       14
`define INST_IMASK_LO   15
`define INST_CG_LO      16
`define INST_CG_DATA    19
`define INST_WREG_LO    6

// ---------------------------------------------------------------
// mode latch codes and reset values
// ---------------------------------------------------------------
`define CG7_RAM_OUT     3'h0
`define CG7_LOAD_MODE   3'h1
`define CG7_DEM_BLOCK   3'h5
`define CG7_RESET       8'h00
`define IMG_TOP_BITS    3'h7
`define BYTE_RESET      8'h00
`define STEP_ONE        8'h01

`endif

// ---- rtl/printer_bus_devices.v ----
//Contract
//- mode latch picks image or bus address
//- image address register loads result bus
//- bus bits 0-4 address legality table
//- eight-way selector gives low-active illegal flag
//- gated legality flag forms transfer stop
//- second accumulator drives input bus when enabled
//- status port puts five inputs on input bus
//- input mask decoder, one output low
//- input mask port drives on its enable
//- first accumulator drives register bus when enabled
//- RAM drives bus when control low and the RAM output mode latch is set
//- RAM writes when control high, strobe low
//- RAM address clears at reset and clear
//- RAM address loads result bus on decode
//- RAM address steps on command or demand
//- RAM address decrements on command
//- sixteen eight-bit working registers
//- working latch captures at phase zero end
//- read-modify-write to same working register
//- data-out register loads at strobe rising edge
//- register mask decoder, one output low
//- register mask port drives when enabled
//- bus address path forces top three bits
//- mode codes set and clear demand block
`timescale 1ns/1ps
`include "printer_bus_defs.vh"
module printer_bus_devices (
	clk,
	srst,
	ce,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	instr,
	result_bus,
	alu_result,
	phase_zero_clk,
	phase_two_clk,
	control_group_seven_n,
	image_addr_reg_load_n,
	image_mem_data,
	acc_two_load_n,
	acc_two_out_en_n,
	acc_one_load_n,
	acc_one_out_en_n,
	status_port_en_n,
	interval_expired_n,
	ram_addr_flag_n,
	band_drive_on_n,
	band_index,
	hammer_pulse_reset_n,
	ram_read_select_n,
	ram_load_decode_n,
	ram_addr_load_n,
	ram_addr_incr_cmd_n,
	ram_addr_decr_cmd_n,
	demand_n,
	workreg_load_n,
	operator_clear,
	regbus_ext_data,
	input_bus_ext_data,
	image_mem_addr,
	char_legal_flag_n,
	transfer_stop_cond,
	input_bus,
	register_bus,
	data_out,
	ram_addr,
	image_addr_source_select,
	ram_output_allow,
	demand_incr_block
);
	input  wire        clk;
	input  wire        srst;
	input  wire        ce;
	input  wire [7:0]  s_axi_awaddr;
	input  wire        s_axi_awvalid;
	output wire        s_axi_awready;
	input  wire [31:0] s_axi_wdata;
	input  wire [3:0]  s_axi_wstrb;
	input  wire        s_axi_wvalid;
	output wire        s_axi_wready;
	output reg  [1:0]  s_axi_bresp;
	output reg         s_axi_bvalid;
	input  wire        s_axi_bready;
	input  wire [7:0]  s_axi_araddr;
	input  wire        s_axi_arvalid;
	output wire        s_axi_arready;
	output reg  [31:0] s_axi_rdata;
	output reg  [1:0]  s_axi_rresp;
	output reg         s_axi_rvalid;
	input  wire        s_axi_rready;
	input  wire [19:0] instr;
	input  wire [7:0]  result_bus;
	input  wire [7:0]  alu_result;
	input  wire        phase_zero_clk;
	input  wire        phase_two_clk;
	input  wire        control_group_seven_n;
	input  wire        image_addr_reg_load_n;
	input  wire [7:0]  image_mem_data;
	input  wire        acc_two_load_n;
	input  wire        acc_two_out_en_n;
	input  wire        acc_one_load_n;
	input  wire        acc_one_out_en_n;
	input  wire        status_port_en_n;
	input  wire        interval_expired_n;
	input  wire        ram_addr_flag_n;
	input  wire        band_drive_on_n;
	input  wire        band_index;
	input  wire        hammer_pulse_reset_n;
	input  wire        ram_read_select_n;
	input  wire        ram_load_decode_n;
	input  wire        ram_addr_load_n;
	input  wire        ram_addr_incr_cmd_n;
	input  wire        ram_addr_decr_cmd_n;
	input  wire        demand_n;
	input  wire        workreg_load_n;
	input  wire        operator_clear;
	input  wire [7:0]  regbus_ext_data;
	input  wire [7:0]  input_bus_ext_data;
	output wire [7:0]  image_mem_addr;
	output wire        char_legal_flag_n;
	output wire        transfer_stop_cond;
	output reg  [7:0]  input_bus;
	output reg  [7:0]  register_bus;
	output reg  [7:0]  data_out;
	output reg  [7:0]  ram_addr;
	output wire        image_addr_source_select;
	output wire        ram_output_allow;
	output wire        demand_incr_block;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function rise;
		input prev;
		input cur;
		begin
			rise = ~prev & cur;
		end
	endfunction

	function fall;
		input prev;
		input cur;
		begin
			fall = prev & ~cur;
		end
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg  [7:0] mode_latch_reg;
	reg  [7:0] image_addr_reg;
	reg  [7:0] acc_one_reg;
	reg  [7:0] acc_two_reg;
	reg  [7:0] work_latch_reg;
	reg  [7:0] workreg [0:15];
	reg  [1:0] ctrl_reg;
	reg        clear_pulse_reg;
	reg        p0_prev_reg;
	reg        ostb_prev_reg;
	reg        acc1_prev_reg;
	reg        acc2_prev_reg;
	reg        dem_prev_reg;
	reg        incr_prev_reg;
	reg        decr_prev_reg;
	reg  [7:0] ram_addr_next;
	wire [7:0] ram_rdata;
	wire [7:0] inmask_n;
	wire [7:0] regmask_n;
	wire [2:0] legal_sel;
	wire       out_reg_strobe_n;
	wire       workreg_read_en_n;
	wire       regbus_maskport_en_n;
	wire       input_bus_maskport_en_n;
	wire       ram_drive_bus_n;
	wire       demand_gated_term;
	wire       ram_write_n;
	wire       ram_addr_step_up_n;
	wire       step_down;
	wire [3:0] wreg_addr;

	assign wreg_addr = instr[`INST_WREG_LO+3:`INST_WREG_LO];

	// ---------------------------------------------------------------
	// mode latches
	// ---------------------------------------------------------------
	// addressable latch: select picks a bit, the data bit sets or
	// clears it while the group strobe is low
	always @(posedge clk) begin
		if (srst) begin
			mode_latch_reg <= `CG7_RESET;
		end else if (ce && !control_group_seven_n) begin
			mode_latch_reg[instr[`INST_CG_LO+2:`INST_CG_LO]] <=
				instr[`INST_CG_DATA];
		end
	end

	assign image_addr_source_select = mode_latch_reg[`CG7_LOAD_MODE];
	assign ram_output_allow         = mode_latch_reg[`CG7_RAM_OUT];
	assign demand_incr_block        = mode_latch_reg[`CG7_DEM_BLOCK];

	// ---------------------------------------------------------------
	// band image addressing and legality
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			image_addr_reg <= `BYTE_RESET;
		end else if (ce && !image_addr_reg_load_n) begin
			image_addr_reg <= result_bus;
		end
	end

	assign image_mem_addr = image_addr_source_select ?
		{`IMG_TOP_BITS, register_bus[4:0]} :
		image_addr_reg;

	// each table word holds eight codes; upper bus bits pick one
	assign legal_sel = register_bus[7:5];
	assign char_legal_flag_n = image_mem_data[legal_sel];
	// only meaningful while the table path is selected
	assign transfer_stop_cond = ~char_legal_flag_n &
		image_addr_source_select & ctrl_reg[`CTRL_GATE_BIT];

	// ---------------------------------------------------------------
	// strobe edge history
	// ---------------------------------------------------------------
	assign out_reg_strobe_n = ~(phase_two_clk & instr[`INST_ALU]);

	always @(posedge clk) begin
		if (srst) begin
			p0_prev_reg   <= 1'b0;
			ostb_prev_reg <= 1'b1;
			acc1_prev_reg <= 1'b1;
			acc2_prev_reg <= 1'b1;
			dem_prev_reg  <= 1'b1;
			incr_prev_reg <= 1'b1;
			decr_prev_reg <= 1'b1;
		end else if (ce) begin
			p0_prev_reg   <= phase_zero_clk;
			ostb_prev_reg <= out_reg_strobe_n;
			acc1_prev_reg <= acc_one_load_n;
			acc2_prev_reg <= acc_two_load_n;
			dem_prev_reg  <= demand_n;
			incr_prev_reg <= ram_addr_incr_cmd_n;
			decr_prev_reg <= ram_addr_decr_cmd_n;
		end
	end

	// ---------------------------------------------------------------
	// accumulators and data-out register
	// ---------------------------------------------------------------
	// edge strobes become clock enables on clk
	always @(posedge clk) begin
		if (srst) begin
			acc_one_reg <= `BYTE_RESET;
			acc_two_reg <= `BYTE_RESET;
			data_out    <= `BYTE_RESET;
		end else if (ce) begin
			if (rise(acc1_prev_reg, acc_one_load_n)) begin
				acc_one_reg <= result_bus;
			end
			if (rise(acc2_prev_reg, acc_two_load_n)) begin
				acc_two_reg <= result_bus;
			end
			if (rise(ostb_prev_reg, out_reg_strobe_n)) begin
				data_out <= alu_result;
			end
		end
	end

	// ---------------------------------------------------------------
	// working registers
	// ---------------------------------------------------------------
	// latch is taken at the end of phase zero, so a write later in
	// the same instruction cannot disturb what the ALU is reading
	always @(posedge clk) begin
		if (srst) begin
			work_latch_reg <= `BYTE_RESET;
		end else if (ce && fall(p0_prev_reg, phase_zero_clk)) begin
			work_latch_reg <= workreg[wreg_addr];
		end
	end

	always @(posedge clk) begin
		if (ce && !workreg_load_n) begin
			workreg[wreg_addr] <= result_bus;
		end
	end

	// ---------------------------------------------------------------
	// data RAM and its address register
	// ---------------------------------------------------------------
	assign ram_drive_bus_n = ~(ram_output_allow & ~ram_read_select_n);
	assign demand_gated_term = ~demand_n & ~demand_incr_block;
	assign ram_write_n = ram_load_decode_n & ~demand_gated_term;
	assign ram_addr_step_up_n = ~(fall(incr_prev_reg,
		ram_addr_incr_cmd_n) |
		(rise(dem_prev_reg, demand_n) & ~demand_incr_block));
	assign step_down = fall(decr_prev_reg, ram_addr_decr_cmd_n);

	data_ram u_ram (
		.clk   (clk),
		.ce    (ce),
		.we    (ram_drive_bus_n & ~ram_write_n),
		.addr  (ram_addr),
		.wdata (register_bus),
		.rdata (ram_rdata)
	);

	always @* begin
		ram_addr_next = ram_addr;
		if (operator_clear || clear_pulse_reg) begin
			ram_addr_next = `BYTE_RESET;
		end else if (!ram_addr_load_n) begin
			ram_addr_next = result_bus;
		end else if (!ram_addr_step_up_n && !step_down) begin
			ram_addr_next = ram_addr + `STEP_ONE;
		end else if (ram_addr_step_up_n && step_down) begin
			ram_addr_next = ram_addr - `STEP_ONE;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			ram_addr <= `BYTE_RESET;
		end else if (ce) begin
			ram_addr <= ram_addr_next;
		end
	end

	// ---------------------------------------------------------------
	// masks and bus steering
	// ---------------------------------------------------------------
	bit_mask_decoder u_inmask (
		.sel    (instr[`INST_IMASK_LO+2:`INST_IMASK_LO]),
		.mask_n (inmask_n)
	);

	bit_mask_decoder u_regmask (
		.sel    (instr[`INST_RMASK_LO+2:`INST_RMASK_LO]),
		.mask_n (regmask_n)
	);

	assign input_bus_maskport_en_n = ~(instr[18] & instr[19]);
	assign workreg_read_en_n = ~(instr[`INST_ALU] & instr[`INST_RDEN]);
	assign regbus_maskport_en_n = workreg_read_en_n |
		~instr[`INST_RMASK_EN];

	// tri-state drivers rebuilt as a priority mux; the far side must
	// keep only one enable active, else the lower source is hidden
	always @* begin
		if (!acc_one_out_en_n) begin
			register_bus = acc_one_reg;
		end else if (!ram_drive_bus_n) begin
			register_bus = ram_rdata;
		end else if (!regbus_maskport_en_n) begin
			register_bus = regmask_n;
		end else if (!workreg_read_en_n) begin
			register_bus = work_latch_reg;
		end else begin
			register_bus = regbus_ext_data;
		end
	end

	always @* begin
		if (!acc_two_out_en_n) begin
			input_bus = acc_two_reg;
		end else if (!status_port_en_n) begin
			input_bus = {3'h0, hammer_pulse_reset_n, band_index,
				band_drive_on_n, ram_addr_flag_n, interval_expired_n};
		end else if (!input_bus_maskport_en_n) begin
			input_bus = inmask_n;
		end else begin
			input_bus = input_bus_ext_data;
		end
	end

	// ---------------------------------------------------------------
	// register bus slave
	// ---------------------------------------------------------------
	reg        aw_held_reg;
	reg        w_held_reg;
	reg  [7:0] aw_addr_reg;
	reg  [7:0] w_byte_reg;
	reg        w_lane_reg;
	reg  [31:0] rd_word;
	reg         rd_ok;

	assign s_axi_awready = ce & ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ce & ~w_held_reg & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;

	always @* begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
		`OFS_CTRL: begin
			rd_word = {30'h0000_0000, ctrl_reg};
		end
		`OFS_RAM_ADDR: begin
			rd_word = {24'h00_0000, ram_addr};
		end
		`OFS_ACCS: begin
			rd_word = {16'h0000, acc_two_reg, acc_one_reg};
		end
		`OFS_FLAGS: begin
			rd_word = {22'h00_0000, transfer_stop_cond,
				char_legal_flag_n, mode_latch_reg};
		end
		default: begin
			rd_ok = 1'b0;
		end
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			aw_addr_reg     <= `BYTE_RESET;
			w_byte_reg      <= `BYTE_RESET;
			w_lane_reg      <= 1'b0;
			s_axi_bvalid    <= 1'b0;
			s_axi_bresp     <= `RESP_OKAY;
			s_axi_rvalid    <= 1'b0;
			s_axi_rresp     <= `RESP_OKAY;
			s_axi_rdata     <= 32'h0000_0000;
			ctrl_reg        <= `CTRL_RESET;
			clear_pulse_reg <= 1'b0;
		end else if (ce) begin
			clear_pulse_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_byte_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (aw_held_reg && w_held_reg) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				if (aw_addr_reg == `OFS_CTRL) begin
					if (w_lane_reg) begin
						ctrl_reg[`CTRL_GATE_BIT] <=
							w_byte_reg[`CTRL_GATE_BIT];
						clear_pulse_reg <= w_byte_reg[`CTRL_CLEAR_BIT];
					end
				end else if (aw_addr_reg != `OFS_RAM_ADDR &&
					aw_addr_reg != `OFS_ACCS &&
					aw_addr_reg != `OFS_FLAGS) begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ---- test/band_image_rom.sv ----
`timescale 1ns/1ps
module band_image_rom (
	input  logic [7:0] addr,
	output logic [7:0] data
);
	// scrambled contents so that legal and illegal codes both occur
	assign data = addr * 8'd37 + 8'h5B;
endmodule

// ---- test/pbd_checker.sv ----
`timescale 1ns/1ps
module pbd_checker (
	input logic        clk, srst, ce, phase_two_clk, operator_clear,
	input logic [19:0] instr,
	input logic [7:0]  result_bus, alu_result, image_mem_addr,
	input logic [7:0]  image_mem_data, register_bus, input_bus,
	input logic [7:0]  ram_addr, data_out,
	input logic        char_legal_flag_n, image_addr_source_select,
	input logic        interval_expired_n, ram_addr_flag_n, band_index,
	input logic        band_drive_on_n, hammer_pulse_reset_n,
	input logic        status_port_en_n, acc_one_out_en_n, acc_two_out_en_n,
	input logic        ram_read_select_n, ram_output_allow, demand_n,
	input logic        ram_addr_load_n, ram_addr_incr_cmd_n,
	input logic        ram_addr_decr_cmd_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ------------------------------------------------
	// bus steering
	// ------------------------------------------------
	property p_img; image_addr_source_select |->
		image_mem_addr == {3'b111, register_bus[4:0]}; endproperty
	a_img: assert property (p_img) else $error("image addr");
	property p_legal; char_legal_flag_n == image_mem_data[register_bus[7:5]];
	endproperty
	a_legal: assert property (p_legal) else $error("legal flag");
	property p_status; !status_port_en_n && acc_two_out_en_n |-> input_bus ==
		{3'b000, hammer_pulse_reset_n, band_index, band_drive_on_n,
		ram_addr_flag_n, interval_expired_n}; endproperty
	a_status: assert property (p_status) else $error("status port");
	property p_inmask; acc_two_out_en_n && status_port_en_n && instr[18] &&
		instr[19] |-> input_bus == 8'(~(8'h01 << instr[17:15])); endproperty
	a_inmask: assert property (p_inmask) else $error("in mask");
	property p_regmask; instr[0] && instr[14] && instr[13] && acc_one_out_en_n
		&& (ram_read_select_n || !ram_output_allow) |->
		register_bus == 8'(~(8'h01 << instr[12:10])); endproperty
	a_regmask: assert property (p_regmask) else $error("reg mask");
	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	property p_clear; ce && operator_clear |=> ram_addr == 8'h00; endproperty
	a_clear: assert property (p_clear) else $error("addr clear");
	property p_load; ce && !operator_clear && !ram_addr_load_n |=>
		ram_addr == $past(result_bus); endproperty
	a_load: assert property (p_load) else $error("addr load");
	// a simultaneous demand rise would cancel the decrement and hold the address, so it is excluded
	property p_decr; ce && !$past(srst) && $fell(ram_addr_decr_cmd_n) &&
		ram_addr_incr_cmd_n && ram_addr_load_n && !operator_clear &&
		$stable(demand_n) |=> ram_addr == 8'($past(ram_addr) - 8'h01);
	endproperty
	a_decr: assert property (p_decr) else $error("addr decr");
	property p_dout; ce && !$past(srst) && $fell(phase_two_clk && instr[0])
		|=> data_out == $past(alu_result); endproperty
	a_dout: assert property (p_dout) else $error("data out");
	c_mode: cover property (image_addr_source_select && !char_legal_flag_n);
	c_decr: cover property ($fell(ram_addr_decr_cmd_n));
	c_port: cover property (!status_port_en_n);
endmodule
bind printer_bus_devices pbd_checker pbd_checker_inst (.*);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "printer_bus_defs.vh"
module tb_top;
	logic        clk = 0, srst = 1, ce = 1, operator_clear = 0;
	logic        phase_zero_clk = 0, phase_two_clk = 0;
	logic [19:0] instr = '0;
	logic [7:0]  result_bus = '0, alu_result = '0, regbus_ext_data = '0;
	logic [7:0]  input_bus_ext_data = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [9:0]  s_n = 10'h3FF;
	logic [3:0]  e_n = 4'hF, s_axi_wstrb = 4'hF;
	logic [4:0]  st = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        char_legal_flag_n, transfer_stop_cond, ram_output_allow;
	logic        image_addr_source_select, demand_incr_block;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]  image_mem_addr, image_mem_data, input_bus, register_bus;
	logic [7:0]  data_out, ram_addr, v, w;
	logic [7:0]  q [16];
	int          fails = 0, n_tests = 0;
	wire acc_one_load_n = s_n[0], acc_two_load_n = s_n[1];
	wire image_addr_reg_load_n = s_n[2], ram_addr_load_n = s_n[3];
	wire ram_addr_incr_cmd_n = s_n[4], ram_addr_decr_cmd_n = s_n[5];
	wire demand_n = s_n[6], workreg_load_n = s_n[7];
	wire control_group_seven_n = s_n[8], ram_load_decode_n = s_n[9];
	wire acc_one_out_en_n = e_n[0], acc_two_out_en_n = e_n[1];
	wire status_port_en_n = e_n[2], ram_read_select_n = e_n[3];
	wire interval_expired_n = st[0], ram_addr_flag_n = st[1];
	wire band_drive_on_n = st[2], band_index = st[3];
	wire hammer_pulse_reset_n = st[4];

	always #10 clk = ~clk;
	printer_bus_devices printer_bus_devices_inst (.*);
	band_image_rom band_image_rom_inst (.addr(image_mem_addr),
		.data(image_mem_data));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [7:0] rnd();
		return 8'($urandom);
	endfunction
	function automatic logic [7:0] rom(input logic [7:0] a);
		return a * 8'd37 + 8'h5B;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic guard(input int k);
		if (k > 100) begin
			fails++;
			$display("ERROR %0t: handshake timeout", $time);
			conclude;
		end
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	// low-active strobe held for one clock
	task automatic pulse(input int i);
		@(posedge clk) s_n[i] <= 0;
		@(posedge clk) s_n[i] <= 1;
		step;
	endtask
	task automatic g7(input logic [2:0] c, input logic b);
		@(posedge clk) instr[19:16] <= {b, c};
		pulse(8);
	endtask
	task automatic ph0;
		@(posedge clk) phase_zero_clk <= 1;
		@(posedge clk) phase_zero_clk <= 0;
		step;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			guard(k++);
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		rs = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] a);
		int k = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			guard(k++);
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask

	initial begin
		rd = $urandom(71);
		repeat (16) @(posedge clk);
		srst <= 0;
		axr(`OFS_RAM_ADDR);
		chk(rd, '0);
		axr(8'h10);
		chk(rs, `RESP_SLVERR);
		axw(8'h14, 32'h1);
		chk(rs, `RESP_SLVERR);
		v = rnd();
		@(posedge clk) result_bus <= v;
		pulse(3);
		chk(ram_addr, v);
		@(posedge clk);
		ce <= 0;
		result_bus <= ~v;
		pulse(3);
		@(posedge clk) ce <= 1;
		step;
		chk(ram_addr, v);
		@(posedge clk) result_bus <= 8'hFF;
		pulse(3);
		pulse(4);
		chk(ram_addr, 8'h00);
		pulse(5);
		chk(ram_addr, 8'hFF);
		pulse(6);
		chk(ram_addr, 8'h00);
		g7(3'h5, 1);
		chk(demand_incr_block, 1'b1);
		pulse(6);
		chk(ram_addr, 8'h00);
		g7(3'h5, 0);
		chk(demand_incr_block, 1'b0);
		pulse(6);
		chk(ram_addr, 8'h01);
		@(posedge clk) operator_clear <= 1;
		@(posedge clk) operator_clear <= 0;
		step;
		chk(ram_addr, 8'h00);
		pulse(4);
		axw(`OFS_CTRL, 32'h3);
		chk(rs, `RESP_OKAY);
		step;
		chk(ram_addr, 8'h00);
		axr(`OFS_CTRL);
		chk(rd, 32'h0000_0002);
		v = rnd();
		w = rnd();
		@(posedge clk) result_bus <= v;
		pulse(0);
		@(posedge clk) result_bus <= w;
		pulse(1);
		@(posedge clk) e_n <= 4'hC;
		step;
		chk(register_bus, v);
		chk(input_bus, w);
		axr(`OFS_ACCS);
		chk(rd, {16'h0, w, v});
		@(posedge clk);
		st <= 5'($urandom);
		e_n <= 4'hB;
		step;
		chk(input_bus, {3'b000, st});
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			e_n <= 4'hF;
			instr <= 20'hC_6001 | 20'(i << 15) | 20'((7 - i) << 10);
			step;
			chk(input_bus, 8'(~(8'h01 << i)));
			chk(register_bus, 8'(~(8'h01 << (7 - i))));
		end
		@(posedge clk) instr <= '0;
		g7(3'h1, 1);
		chk(image_addr_source_select, 1'b1);
		repeat (8) begin
			@(posedge clk);
			regbus_ext_data <= rnd();
			input_bus_ext_data <= rnd();
			step;
			v = {3'b111, regbus_ext_data[4:0]};
			w = rom(v);
			chk(image_mem_addr, v);
			chk(char_legal_flag_n, w[regbus_ext_data[7:5]]);
			chk(transfer_stop_cond, !w[regbus_ext_data[7:5]]);
			chk(input_bus, input_bus_ext_data);
		end
		axr(`OFS_FLAGS);
		chk(rd, {22'h0, !w[regbus_ext_data[7:5]],
			w[regbus_ext_data[7:5]], 8'h02});
		g7(3'h1, 0);
		chk(image_addr_source_select, 1'b0);
		v = 8'($urandom_range(191));
		@(posedge clk) result_bus <= v;
		pulse(2);
		chk(image_mem_addr, v);
		g7(3'h0, 1);
		chk(ram_output_allow, 1'b1);
		for (int i = 0; i < 4; i++) begin
			q[i] = rnd();
			@(posedge clk);
			result_bus <= 8'(i * 67);
			regbus_ext_data <= q[i];
			pulse(3);
			pulse(9);
		end
		for (int i = 3; i >= 0; i--) begin
			@(posedge clk);
			e_n <= 4'hF;
			result_bus <= 8'(i * 67);
			regbus_ext_data <= ~q[i];
			pulse(3);
			@(posedge clk) e_n <= 4'h7;
			step;
			chk(register_bus, q[i]);
		end
		@(posedge clk) e_n <= 4'hF;
		for (int i = 0; i < 16; i++) begin
			q[i] = rnd();
			@(posedge clk);
			instr <= 20'(i << 6);
			result_bus <= q[i];
			pulse(7);
		end
		for (int i = 0; i < 16; i++) begin
			@(posedge clk) instr <= 20'h0_4001 | 20'(i << 6);
			ph0;
			chk(register_bus, q[i]);
		end
		@(posedge clk) result_bus <= 8'(q[15] + 8'h01);
		pulse(7);
		chk(register_bus, q[15]);
		ph0;
		chk(register_bus, 8'(q[15] + 8'h01));
		w = 8'h00;
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			@(posedge clk);
			alu_result <= v;
			instr[0] <= i[0];
			phase_two_clk <= 1;
			@(posedge clk) phase_two_clk <= 0;
			step;
			if (i[0]) w = v;
			chk(data_out, w);
		end
		conclude;
	end
endmodule
